/* dv/atcr_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Far side of the timer: count and trigger pins, serial port mode and the other timer
module atcr_pin_model (
	// Clock
	input  wire logic       aclk,
	// Pins toward the timer
	output logic            count_input_pin,
	output logic            trigger_pin,
	// Serial port side
	output logic      [1:0] uart_mode,
	output logic            other_timer_wrap,
	input  wire logic       rx_baud_tick,
	input  wire logic       tx_baud_tick
);
	int unsigned rx_seen;
	int unsigned tx_seen;
	logic [3:0]  phase_r;

	// Pins idle high so that only a deliberate drop makes an edge
	initial begin
		count_input_pin  = 1'b1;
		trigger_pin      = 1'b1;
		uart_mode        = 2'h0;
		other_timer_wrap = 1'b0;
		phase_r          = 4'h0;
		rx_seen          = 0;
		tx_seen          = 0;
	end

	// Other timer wraps every 16 clocks; ticks from the timer are tallied
	always @(posedge aclk) begin
		phase_r          <= phase_r + 4'h1;
		other_timer_wrap <= (phase_r == 4'hF);
		if (rx_baud_tick === 1'b1) rx_seen <= rx_seen + 1;
		if (tx_baud_tick === 1'b1) tx_seen <= tx_seen + 1;
	end

	// Each level is held at least three clocks so both samples of an edge see it
	task automatic fall(input bit trig, input int n);
		repeat (n) begin
			@(posedge aclk);
			if (trig) trigger_pin <= 1'b0;
			else count_input_pin <= 1'b0;
			repeat (3) @(posedge aclk);
			if (trig) trigger_pin <= 1'b1;
			else count_input_pin <= 1'b1;
			repeat (3) @(posedge aclk);
		end
	endtask: fall

	// Serial port mode changes just after an edge
	task automatic set_mode(input logic [1:0] m);
		@(posedge aclk);
		uart_mode <= m;
	endtask: set_mode
endmodule: atcr_pin_model

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import atcr_pkg::*;
;
	logic        aclk;
	logic        aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r, uart_mode;
	logic        cnt_pin, trg_pin, other_wrap, rx_tick, tx_tick, irq;
	int          err_total, checked, cyc_n, t0, half, a, b;
	logic [7:0]  ctl [3] = '{8'h20, 8'h10, 8'h34};
	logic        en;

	atcr_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.count_input_pin(cnt_pin), .trigger_pin(trg_pin), .uart_mode(uart_mode),
		.other_timer_wrap(other_wrap), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .irq(irq));

	atcr_pin_model i_pins (.aclk(aclk), .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
		.uart_mode(uart_mode), .other_timer_wrap(other_wrap), .rx_baud_tick(rx_tick),
		.tx_baud_tick(tx_tick));

	// 100 MHz clock
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge aclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 10000) begin
			err_total++;
			conclude();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask: chk

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr  <= ad;
		wvalid  <= 1'b1;
		wdata   <= dt;
		wstrb   <= 4'hF;
		bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		chk("bresp", 32'(er), 32'(bresp));
		bready <= 1'b0;
	endtask: wr

	task automatic rdr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr  <= ad;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		dt = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask: rdr

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] dt;
		logic [1:0]  rs;
		rdr(ad, dt, rs);
		chk("rdata", e, dt);
		chk("rresp", 32'(er), 32'(rs));
	endtask: rd

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask: conclude

	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{err_total, checked, cyc_n} = 96'h0;
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset contents and unmapped places
		rd(ATCR_OFF_CONTROL, 32'h0, RESP_OKAY);
		rd(ATCR_OFF_COUNT, 32'h0, RESP_OKAY);
		rd(ATCR_OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		rd(8'h18, 32'h0, RESP_SLVERR);
		wr(8'h18, 32'hFFFF, RESP_SLVERR);
		wr(ATCR_OFF_RELOAD, 32'hABCD5A5A, RESP_OKAY);
		rd(ATCR_OFF_RELOAD, 32'h5A5A, RESP_OKAY);
		// Timer source rate, then hold when stopped
		wr(ATCR_OFF_COUNT, 32'h0, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h04, RESP_OKAY);
		t0 = cyc_n;
		repeat (100) @(posedge aclk);
		wr(ATCR_OFF_CONTROL, 32'h00, RESP_OKAY);
		half = (cyc_n - t0) / 2;
		rdr(ATCR_OFF_COUNT, d, r);
		chk("timer rate", 32'h1, 32'(d >= half - 2 && d <= half + 2));
		repeat (20) @(posedge aclk);
		rd(ATCR_OFF_COUNT, d, RESP_OKAY);
		// Wrap in reload mode raises the flag and the interrupt
		wr(ATCR_OFF_RELOAD, 32'h1234, RESP_OKAY);
		wr(ATCR_OFF_COUNT, 32'hFFF0, RESP_OKAY);
		wr(ATCR_OFF_IRQ_ENABLE, 32'h1, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h04, RESP_OKAY);
		repeat (40) @(posedge aclk);
		rd(ATCR_OFF_CONTROL, 32'h84, RESP_OKAY);
		chk("irq", 32'h1, 32'(irq));
		wr(ATCR_OFF_CONTROL, 32'h00, RESP_OKAY);
		rdr(ATCR_OFF_COUNT, d, r);
		chk("reload", 32'h1, 32'(d >= 32'h1234 && d <= 32'h1250));
		rd(ATCR_OFF_CONTROL, 32'h0, RESP_OKAY);
		rd(ATCR_OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
		wr(ATCR_OFF_IRQ_CLEAR, 32'h1, RESP_OKAY);
		rd(ATCR_OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		chk("irq", 32'h0, 32'(irq));
		// Counter source: each pin fall counts once, none while stopped
		wr(ATCR_OFF_COUNT, 32'h0, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h06, RESP_OKAY);
		i_pins.fall(1'b0, 5);
		wr(ATCR_OFF_CONTROL, 32'h02, RESP_OKAY);
		i_pins.fall(1'b0, 2);
		rd(ATCR_OFF_COUNT, 32'h5, RESP_OKAY);
		// Trigger gating, then trigger reload
		wr(ATCR_OFF_IRQ_ENABLE, 32'h2, RESP_OKAY);
		wr(ATCR_OFF_RELOAD, 32'h55, RESP_OKAY);
		wr(ATCR_OFF_COUNT, 32'h100, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h18, RESP_OKAY);
		i_pins.fall(1'b1, 1);
		rd(ATCR_OFF_COUNT, 32'h100, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h00, RESP_OKAY);
		i_pins.fall(1'b1, 1);
		rd(ATCR_OFF_COUNT, 32'h100, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h08, RESP_OKAY);
		i_pins.fall(1'b1, 1);
		rd(ATCR_OFF_COUNT, 32'h55, RESP_OKAY);
		rd(ATCR_OFF_CONTROL, 32'h48, RESP_OKAY);
		chk("irq", 32'h1, 32'(irq));
		// Capture copies the count; a software zero clears the flag first
		wr(ATCR_OFF_CONTROL, 32'h09, RESP_OKAY);
		wr(ATCR_OFF_COUNT, 32'hAB, RESP_OKAY);
		i_pins.fall(1'b1, 1);
		rd(ATCR_OFF_RELOAD, 32'hAB, RESP_OKAY);
		rd(ATCR_OFF_CONTROL, 32'h49, RESP_OKAY);
		wr(ATCR_OFF_IRQ_CLEAR, 32'h2, RESP_OKAY);
		chk("irq", 32'h0, 32'(irq));
		// Capture mode wraps to zero, not to the reload value, and still raises wrap status
		wr(ATCR_OFF_COUNT, 32'hFFFE, RESP_OKAY);
		wr(ATCR_OFF_CONTROL, 32'h05, RESP_OKAY);
		repeat (4) @(posedge aclk);
		wr(ATCR_OFF_CONTROL, 32'h01, RESP_OKAY);
		rdr(ATCR_OFF_COUNT, d, r);
		chk("capture wrap", 32'h1, 32'(d <= 32'h4));
		rd(ATCR_OFF_IRQ_STATUS, 32'h1, RESP_OKAY);
		// Baud clock routing across selects and serial modes
		wr(ATCR_OFF_RELOAD, 32'hFFF0, RESP_OKAY);
		wr(ATCR_OFF_COUNT, 32'hFFF0, RESP_OKAY);
		for (int k = 0; k < 3; k++) begin
			for (int m = 0; m < 4; m++) begin
				i_pins.set_mode(2'(m));
				wr(ATCR_OFF_CONTROL, 32'(ctl[k]), RESP_OKAY);
				a = i_pins.rx_seen;
				b = i_pins.tx_seen;
				repeat (100) @(posedge aclk);
				en = (m == 1) || (m == 3);
				chk("rx ticks", 32'(en && (!ctl[k][5] || ctl[k][2])), 32'(i_pins.rx_seen != a));
				chk("tx ticks", 32'(en && (!ctl[k][4] || ctl[k][2])), 32'(i_pins.tx_seen != b));
				rd(ATCR_OFF_CONTROL, 32'(ctl[k]), RESP_OKAY);
			end
		end
		conclude();
	end
endmodule: tb_top

`default_nettype wire

/* rtl/atcr_axil.sv */
`timescale 1ns/100ps
`default_nettype none

module atcr_axil
	import atcr_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// Write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	// Read address and data
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	// Register side
	atcr_reg_if.bus          rb
);
	typedef enum logic [0:0] {ATCR_WR_IDLE, ATCR_WR_RESP} atcr_wr_state_t;

	typedef struct packed {
		atcr_wr_state_t wst;
		logic           awready;
		logic           wready;
		logic           aw_have;
		logic           w_have;
		logic [7:0]     awaddr;
		logic [31:0]    wdata;
		logic [3:0]     wstrb;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           arready;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
	} atcr_axil_state_t;

	atcr_axil_state_t s_r;
	atcr_axil_state_t s_nxt;
	logic             do_write;

	// Write fires in the same cycle that both halves are held
	assign do_write = s_r.aw_have & s_r.w_have & (s_r.wst == ATCR_WR_IDLE);

	// Address and data are latched in either order; read answers a cycle after the address
	always_comb begin
		s_nxt = s_r;
		case (s_r.wst)
			ATCR_WR_IDLE: begin
				if (s_axi_awvalid && s_r.awready) begin
					s_nxt.aw_have = 1'h1;
					s_nxt.awaddr  = s_axi_awaddr;
				end
				if (s_axi_wvalid && s_r.wready) begin
					s_nxt.w_have = 1'h1;
					s_nxt.wdata  = s_axi_wdata;
					s_nxt.wstrb  = s_axi_wstrb;
				end
				if (do_write) begin
					s_nxt.wst     = ATCR_WR_RESP;
					s_nxt.aw_have = 1'h0;
					s_nxt.w_have  = 1'h0;
					s_nxt.bvalid  = 1'h1;
					s_nxt.bresp   = atcr_addr_known(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
				end
			end
			ATCR_WR_RESP: begin
				if (s_axi_bready) begin
					s_nxt.bvalid = 1'h0;
					s_nxt.wst    = ATCR_WR_IDLE;
				end
			end
			default: s_nxt.wst = ATCR_WR_IDLE;
		endcase
		s_nxt.awready = !s_nxt.aw_have && (s_nxt.wst == ATCR_WR_IDLE);
		s_nxt.wready  = !s_nxt.w_have && (s_nxt.wst == ATCR_WR_IDLE);
		if (s_r.rvalid) begin
			if (s_axi_rready) begin
				s_nxt.rvalid = 1'h0;
			end
		end else if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'h1;
			s_nxt.rdata  = atcr_addr_known(s_axi_araddr) ? rb.rd_data : 32'h0000_0000;
			s_nxt.rresp  = atcr_addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		s_nxt.arready = !s_nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register, except wr_en decoded from it and rd_addr taken from the read address input
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready  = s_r.wready;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign rb.wr_en      = do_write;
	assign rb.wr_addr    = s_r.awaddr;
	assign rb.wr_data    = s_r.wdata;
	assign rb.wr_strb    = s_r.wstrb;
	assign rb.rd_addr    = s_axi_araddr;

endmodule: atcr_axil

`default_nettype wire

/* rtl/atcr_pin_edge.sv */
`timescale 1ns/100ps
`default_nettype none

module atcr_pin_edge
	import atcr_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Pins in, falling edges out
	input  wire logic [1:0] pins,
	output logic      [1:0] fall
);
	typedef struct packed {
		logic [1:0] cur;
		logic [1:0] prev;
	} atcr_pin_state_t;

	atcr_pin_state_t s_r;
	atcr_pin_state_t s_nxt;

	// Two samples per pin; low reset avoids a false edge at release
	always_comb begin
		s_nxt      = s_r;
		s_nxt.cur  = pins;
		s_nxt.prev = s_r.cur;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// High sample then low sample makes one edge pulse
	genvar i;
	for (i = 0; i < 2; i++) begin : g_pin
		assign fall[i] = s_r.prev[i] & ~s_r.cur[i];

		edge_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
			fall[i] |=> !fall[i])
			else $error("edge pulse lasted more than one cycle");
		edge_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
			fall[i] |-> ($past(pins[i], 2) && !$past(pins[i])))
			else $error("edge pulse without a high then low sample");
	end

endmodule: atcr_pin_edge

`default_nettype wire

/* rtl/atcr_pkg.sv */
package atcr_pkg;

	// Register byte offsets
	localparam logic [7:0] ATCR_OFF_CONTROL    = 8'h00;
	localparam logic [7:0] ATCR_OFF_COUNT      = 8'h04;
	localparam logic [7:0] ATCR_OFF_RELOAD     = 8'h08;
	localparam logic [7:0] ATCR_OFF_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ATCR_OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ATCR_OFF_IRQ_CLEAR  = 8'h14;

	// Control register bit positions
	localparam int unsigned CTL_WRAP_FLAG = 7;
	localparam int unsigned CTL_TRIG_FLAG = 6;
	localparam int unsigned CTL_RX_SEL    = 5;
	localparam int unsigned CTL_TX_SEL    = 4;
	localparam int unsigned CTL_TRIG_EN   = 3;
	localparam int unsigned CTL_RUN       = 2;
	localparam int unsigned CTL_SRC       = 1;
	localparam int unsigned CTL_CAPMODE   = 0;

	// Interrupt status/enable/clear bit positions
	localparam int unsigned IRQ_WRAP = 0;
	localparam int unsigned IRQ_TRIG = 1;

	// Pin index inside the edge detector
	localparam int unsigned PIN_COUNT = 0;
	localparam int unsigned PIN_TRIG  = 1;

	// Reset values and count limits
	localparam logic [7:0]  CONTROL_RST = 8'h00;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [15:0] RELOAD_RST  = 16'h0000;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
	localparam logic [15:0] COUNT_WRAP  = 16'h0000;
	localparam logic [1:0]  IRQ_RST     = 2'h0;

	// Timer mode advances once per TIMER_DIV system clocks
	localparam int unsigned TIMER_DIV = 2;
	localparam logic [0:0]  DIV_LAST  = 1'(TIMER_DIV - 1);

	// Serial modes that take a baud overflow
	localparam logic [1:0] UART_MODE1 = 2'h1;
	localparam logic [1:0] UART_MODE3 = 2'h3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Address decode shared by read and write paths
	function automatic logic atcr_addr_known(input logic [7:0] a);
		return (a == ATCR_OFF_CONTROL) || (a == ATCR_OFF_COUNT) || (a == ATCR_OFF_RELOAD) ||
			(a == ATCR_OFF_IRQ_STATUS) || (a == ATCR_OFF_IRQ_ENABLE) || (a == ATCR_OFF_IRQ_CLEAR);
	endfunction: atcr_addr_known

	// Byte-lane merge for 16-bit registers
	function automatic logic [15:0] atcr_merge16(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] strb);
		return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
	endfunction: atcr_merge16

endpackage: atcr_pkg

/* rtl/atcr_reg_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Register access between the bus slave and the timer core
interface atcr_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;

	modport bus  (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr,
		input rd_data);
	modport core (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr,
		output rd_data);
endinterface: atcr_reg_if

`default_nettype wire

/* rtl/atcr_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Wrap sets the wrap flag unless a baud select is on; software clears it.
// - A pin-caused capture or reload sets the trigger flag; only software clears it.
// - Receive select picks own wrap, else other timer, as receive clock in modes 1/3.
// - Transmit select picks own wrap, else other timer, as transmit clock in modes 1/3.
// - Trigger edges act only with trigger enable on and both baud selects off.
// - Count advances while run control is 1 and, but for trigger reloads, holds while it is 0.
// - Timer source advances the count once every two system clocks.
// - Counter source advances the count on each falling edge of the count pin.
// - Reload mode loads the reload value on wrap and on enabled trigger edges.
// - Capture mode copies the count into the reload register on enabled trigger edges.
module atcr_top
	import atcr_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	// External pins
	input  wire logic        count_input_pin,
	input  wire logic        trigger_pin,
	// Serial port baud clocks
	input  wire logic [1:0]  uart_mode,
	input  wire logic        other_timer_wrap,
	output logic             rx_baud_tick,
	output logic             tx_baud_tick,
	// Interrupt
	output logic             irq
);
	typedef struct packed {
		logic [7:0]  ctl;
		logic [15:0] count;
		logic [15:0] reload;
		logic [1:0]  irq_st;
		logic [1:0]  irq_en;
		logic [0:0]  div;
		logic        rx_tick;
		logic        tx_tick;
		logic        irq;
	} atcr_core_t;

	localparam atcr_core_t CORE_RST = '{
		ctl:     CONTROL_RST,
		count:   COUNT_RST,
		reload:  RELOAD_RST,
		irq_st:  IRQ_RST,
		irq_en:  IRQ_RST,
		div:     1'h0,
		rx_tick: 1'h0,
		tx_tick: 1'h0,
		irq:     1'h0
	};

	atcr_core_t  st_r;
	atcr_core_t  st_nxt;
	atcr_reg_if  rb ();
	logic [1:0]  pin_fall;
	logic        cnt_fall;
	logic        trig_fall;
	logic        baud;
	logic        trig;
	logic        inc;
	logic        ovf;
	logic        mode_ok;
	logic [1:0]  ev;
	logic        wr_ctl;
	logic        wr_cnt;
	logic        wr_rld;
	logic        wr_ien;
	logic        wr_clr;

	// Bus slave
	atcr_axil u_axil (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.rb            (rb.bus)
	);

	// Pin sampling and edge detection
	atcr_pin_edge u_pins (
		.aclk    (aclk),
		.aresetn (aresetn),
		.pins    ({trigger_pin, count_input_pin}),
		.fall    (pin_fall)
	);

	// Write decode; control byte lives in lane 0
	assign wr_ctl = rb.wr_en & (rb.wr_addr == ATCR_OFF_CONTROL) & rb.wr_strb[0];
	assign wr_cnt = rb.wr_en & (rb.wr_addr == ATCR_OFF_COUNT);
	assign wr_rld = rb.wr_en & (rb.wr_addr == ATCR_OFF_RELOAD);
	assign wr_ien = rb.wr_en & (rb.wr_addr == ATCR_OFF_IRQ_ENABLE) & rb.wr_strb[0];
	assign wr_clr = rb.wr_en & (rb.wr_addr == ATCR_OFF_IRQ_CLEAR) & rb.wr_strb[0];

	// Event qualification
	assign cnt_fall  = pin_fall[PIN_COUNT];
	assign trig_fall = pin_fall[PIN_TRIG];
	assign baud      = st_r.ctl[CTL_RX_SEL] | st_r.ctl[CTL_TX_SEL];
	assign trig      = trig_fall & st_r.ctl[CTL_TRIG_EN] & ~baud;
	assign inc       = st_r.ctl[CTL_RUN] &
		(st_r.ctl[CTL_SRC] ? cnt_fall : (st_r.div == DIV_LAST));
	assign ovf       = inc & (st_r.count == COUNT_MAX);
	assign mode_ok   = (uart_mode == UART_MODE1) | (uart_mode == UART_MODE3);
	assign ev[IRQ_WRAP] = ovf & ~baud;
	assign ev[IRQ_TRIG] = trig;

	// Read mux; clear register is write-only and reads zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input atcr_core_t s);
		case (a)
			ATCR_OFF_CONTROL:    return {24'h00_0000, s.ctl};
			ATCR_OFF_COUNT:      return {16'h0000, s.count};
			ATCR_OFF_RELOAD:     return {16'h0000, s.reload};
			ATCR_OFF_IRQ_STATUS: return {30'h0000_0000, s.irq_st};
			ATCR_OFF_IRQ_ENABLE: return {30'h0000_0000, s.irq_en};
			default:             return 32'h0000_0000;
		endcase
	endfunction: rd_mux

	assign rb.rd_data = rd_mux(rb.rd_addr, st_r);

	// Next state; hardware updates first, software bytes override, flag sets always win
	always_comb begin
		st_nxt     = st_r;
		// Free-running divider keeps timer mode phase fixed
		st_nxt.div = (st_r.div == DIV_LAST) ? 1'h0 : st_r.div + 1'h1;
		if (inc) begin
			if (ovf) begin
				// Baud use forces auto-reload so the bit rate stays programmable
				st_nxt.count = (st_r.ctl[CTL_CAPMODE] && !baud) ? COUNT_WRAP : st_r.reload;
			end else begin
				st_nxt.count = st_r.count + 16'h0001;
			end
		end
		if (trig) begin
			if (st_r.ctl[CTL_CAPMODE]) begin
				st_nxt.reload = st_r.count;
			end else begin
				st_nxt.count = st_r.reload;
			end
		end
		if (wr_ctl) begin
			st_nxt.ctl = rb.wr_data[7:0];
		end
		st_nxt.ctl[CTL_WRAP_FLAG] = st_nxt.ctl[CTL_WRAP_FLAG] | ev[IRQ_WRAP];
		st_nxt.ctl[CTL_TRIG_FLAG] = st_nxt.ctl[CTL_TRIG_FLAG] | ev[IRQ_TRIG];
		if (wr_cnt) begin
			st_nxt.count = atcr_merge16(st_nxt.count, rb.wr_data[15:0], rb.wr_strb[1:0]);
		end
		if (wr_rld) begin
			st_nxt.reload = atcr_merge16(st_nxt.reload, rb.wr_data[15:0], rb.wr_strb[1:0]);
		end
		if (wr_ien) begin
			st_nxt.irq_en = rb.wr_data[1:0];
		end
		// Sticky status, write-one-to-clear, a same-cycle event survives
		st_nxt.irq_st  = (st_r.irq_st & ~(wr_clr ? rb.wr_data[1:0] : IRQ_RST)) | ev;
		st_nxt.irq     = |(st_nxt.irq_st & st_nxt.irq_en);
		// Baud ticks are only meaningful to the serial port in modes 1 and 3
		st_nxt.rx_tick = mode_ok & (st_r.ctl[CTL_RX_SEL] ? ovf : other_timer_wrap);
		st_nxt.tx_tick = mode_ok & (st_r.ctl[CTL_TX_SEL] ? ovf : other_timer_wrap);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= CORE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs from the state register
	assign rx_baud_tick = st_r.rx_tick;
	assign tx_baud_tick = st_r.tx_tick;
	assign irq          = st_r.irq;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wrap_flag_set_a: assert property (
		(ovf && !baud) |=> st_r.ctl[CTL_WRAP_FLAG])
		else $error("wrap flag not set on wrap");

	baud_no_wrap_a: assert property (
		(!st_r.ctl[CTL_WRAP_FLAG] && baud && !rb.wr_en) |=> !st_r.ctl[CTL_WRAP_FLAG])
		else $error("wrap flag set while a baud select is on");

	trig_flag_set_a: assert property (
		trig |=> st_r.ctl[CTL_TRIG_FLAG])
		else $error("trigger flag not set on trigger edge");

	trig_flag_hold_a: assert property (
		(st_r.ctl[CTL_TRIG_FLAG] && !wr_ctl) |=> st_r.ctl[CTL_TRIG_FLAG])
		else $error("trigger flag cleared without a software write");

	rx_tick_src_a: assert property (
		(mode_ok && (st_r.ctl[CTL_RX_SEL] ? ovf : other_timer_wrap)) |=> rx_baud_tick)
		else $error("receive baud tick missing");

	tx_tick_gate_a: assert property (
		(!mode_ok || (st_r.ctl[CTL_TX_SEL] && !ovf)) |=> !tx_baud_tick)
		else $error("transmit baud tick from wrong source");

	trig_gated_a: assert property (
		(trig_fall && (baud || !st_r.ctl[CTL_TRIG_EN]) && !st_r.ctl[CTL_TRIG_FLAG] && !rb.wr_en)
		|=> !st_r.ctl[CTL_TRIG_FLAG])
		else $error("trigger edge acted while gated off");

	run_hold_a: assert property (
		(!st_r.ctl[CTL_RUN] && !trig && !rb.wr_en) |=> (st_r.count == $past(st_r.count)))
		else $error("count moved while stopped");

	timer_rate_a: assert property (
		(st_r.ctl[CTL_RUN] && !st_r.ctl[CTL_SRC] && !trig && !rb.wr_en && st_r.count < 16'hFFFE) [*2]
		|=> (st_r.count == $past(st_r.count, 2) + 16'h0001))
		else $error("timer mode rate is not one step per two clocks");

	counter_edge_a: assert property (
		(st_r.ctl[CTL_RUN] && st_r.ctl[CTL_SRC] && !trig && !rb.wr_en && st_r.count != COUNT_MAX)
		|=> (st_r.count == $past(st_r.count) + {15'h0000, $past(cnt_fall)}))
		else $error("counter mode step does not follow pin edges");

	reload_load_a: assert property (
		((ovf || trig) && !st_r.ctl[CTL_CAPMODE] && !rb.wr_en) |=> (st_r.count == $past(st_r.reload)))
		else $error("reload value not loaded");

	capture_a: assert property (
		(trig && st_r.ctl[CTL_CAPMODE] && !rb.wr_en) |=> (st_r.reload == $past(st_r.count)))
		else $error("count not captured on trigger edge");

	rx_tick_gate_a: assert property (
		(!mode_ok || (st_r.ctl[CTL_RX_SEL] && !ovf)) |=> !rx_baud_tick)
		else $error("receive baud tick from wrong source");

	tx_tick_src_a: assert property (
		(mode_ok && (st_r.ctl[CTL_TX_SEL] ? ovf : other_timer_wrap)) |=> tx_baud_tick)
		else $error("transmit baud tick missing");

	wrap_flag_hold_a: assert property (
		(st_r.ctl[CTL_WRAP_FLAG] && !wr_ctl) |=> st_r.ctl[CTL_WRAP_FLAG])
		else $error("wrap flag cleared without a software write");

	wrap_status_a: assert property (
		ev[IRQ_WRAP] |=> st_r.irq_st[IRQ_WRAP])
		else $error("wrap status bit not set on wrap");

	trig_status_a: assert property (
		ev[IRQ_TRIG] |=> st_r.irq_st[IRQ_TRIG])
		else $error("trigger status bit not set on trigger edge");

	irq_level_a: assert property (
		irq == |(st_r.irq_st & st_r.irq_en))
		else $error("interrupt level disagrees with enabled status");

	stop_no_inc_a: assert property (
		!st_r.ctl[CTL_RUN] |-> !inc)
		else $error("count step requested while stopped");

	cap_wrap_zero_a: assert property (
		(ovf && st_r.ctl[CTL_CAPMODE] && !baud && !rb.wr_en) |=> (st_r.count == COUNT_WRAP))
		else $error("capture mode wrap did not return to zero");

endmodule: atcr_top

`default_nettype wire
